// >>> core/tsr_device.sv
// Sensor end: pointer, registers, conversion pacing and over-temperature filter
`timescale 1ns/10ps
`default_nettype none
module tsr_device #(
   parameter longint CONV_CYCLES = tsr_pkg::CONV_CYC,
   parameter longint P0_CYCLES = tsr_pkg::PER_4S_CYC,
   parameter longint P1_CYCLES = tsr_pkg::PER_1S_CYC,
   parameter longint P2_CYCLES = tsr_pkg::PER_250_CYC,
   parameter longint P3_CYCLES = tsr_pkg::PER_125_CYC
) (
   input wire logic clk,
   input wire logic srst,
   tsr_link_if.dev link,
   input wire logic [11:0] sensor_code,
   output logic conv_busy,
   output logic [7:0] pointer
);
   localparam int N = tsr_pkg::FRAME_BITS;
   logic [2:0] s_q;
   logic [2:0] s_rise;
   logic [15:0] ctrl;
   logic [15:0] lower;
   logic [15:0] upper;
   logic [15:0] result;
   logic flag_raw;
   logic latched;
   logic [2:0] run;
   logic [31:0] tick;
   logic first_done;
   logic [N-1:0] shreg;
   logic [4:0] bitcnt;
   logic [15:0] tx;
   logic dev_dat;
   logic dev_dat_oe;
   logic over_temp;
   logic rd_frame;
   logic tx_load;
   tsr_sync #(.W(3)) tsr_sync_inst (
      .clk(clk),
      .srst(srst),
      .d({link.link_clk, link.frame, link.host_dat}),
      .q(s_q),
      .rise(s_rise)
   );
   // Frame decode on sampled link
   wire frame_on = s_q[1];
   wire frame_end = ~s_q[1] & (bitcnt != 5'h0);
   wire sclk_rise = s_rise[2] & frame_on;
   wire is_write = shreg[N-1];
   wire [1:0] fptr = shreg[N-2:N-3];
   wire [15:0] fdata = shreg[15:0];
   wire wr_go = frame_end & (bitcnt == 5'(N)) & is_write;
   // Pointer bits are complete at the third link clock rise of every frame
   wire ptr_go = sclk_rise & (bitcnt == 5'h2);
   wire rd_go = frame_end & (bitcnt == 5'(N)) & ~is_write;
   // Current register image
   // Flag bit follows output sense so it matches the pin in comparator mode
   wire flag_bit = flag_raw ^ ctrl[tsr_pkg::SENSE_BIT];
   wire [15:0] ctrl_img = (ctrl & tsr_pkg::CTRL_WMASK) | tsr_pkg::CTRL_ONES
      | (16'(flag_bit) << tsr_pkg::FLAG_BIT);
   wire [15:0] rd_img = (pointer[1:0] == tsr_pkg::PTR_RESULT) ? result :
      (pointer[1:0] == tsr_pkg::PTR_CONTROL) ? ctrl_img :
      (pointer[1:0] == tsr_pkg::PTR_LOWER) ? lower : upper;
   // Conversion pacing
   wire [1:0] per_sel = ctrl[tsr_pkg::PERIOD_LO+:2];
   wire [31:0] period = (per_sel == 2'h0) ? 32'(P0_CYCLES) :
      (per_sel == 2'h1) ? 32'(P1_CYCLES) :
      (per_sel == 2'h2) ? 32'(P2_CYCLES) : 32'(P3_CYCLES);
   wire conv_end = conv_busy & (tick >= 32'(CONV_CYCLES) - 32'h1);
   wire due = ~conv_busy & (tick >= period - 32'(CONV_CYCLES) - 32'h1)
      & first_done;
   // Threshold filter
   wire [11:0] temp = sensor_code;
   wire above = $signed(temp) >= $signed(upper[15:4]);
   wire below = $signed(temp) <= $signed(lower[15:4]);
   wire qual = flag_raw ? above : below;
   wire [2:0] need = 3'(ctrl[tsr_pkg::FAULT_LO+:2]) + 3'h1;
   wire hit = conv_end & qual & (run + 3'h1 >= need);
   wire sense = ctrl[tsr_pkg::SENSE_BIT];
   wire latch_mode = ctrl[tsr_pkg::LATCH_BIT];
   // Flag level 1 idle; active level per output sense
   wire active_now = latch_mode ? latched : ~flag_raw;
   wire next_over_temp = sense ? active_now : ~active_now;
   // Link shift and register writes
   always_ff @(posedge clk) begin
      if (srst) begin
         shreg <= '0;
         bitcnt <= '0;
      end else if (frame_end) begin
         bitcnt <= '0;
      end else if (sclk_rise) begin
         shreg <= {shreg[N-2:0], s_q[0]};
         bitcnt <= bitcnt + 5'h1;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         pointer <= 8'h00;
         ctrl <= tsr_pkg::CTRL_RESET;
         lower <= tsr_pkg::LOWER_RESET;
         upper <= tsr_pkg::UPPER_RESET;
      end else begin
         if (ptr_go) pointer <= {6'h00, shreg[0], s_q[0]};
         if (wr_go) begin
            pointer <= {6'h00, fptr};
            unique case (fptr)
               tsr_pkg::PTR_CONTROL: ctrl <= fdata & tsr_pkg::CTRL_WMASK;
               tsr_pkg::PTR_LOWER: lower <= fdata & tsr_pkg::LIMIT_MASK;
               tsr_pkg::PTR_UPPER: upper <= fdata & tsr_pkg::LIMIT_MASK;
               tsr_pkg::PTR_RESULT: ; // Read-only, dropped
            endcase
         end
      end
   end
   // Conversion timer: starts at reset release
   always_ff @(posedge clk) begin
      if (srst) begin
         conv_busy <= 1'b1;
         tick <= '0;
         first_done <= 1'b0;
      end else if (conv_end | due) begin
         conv_busy <= due;
         tick <= '0;
         first_done <= 1'b1;
      end else begin
         tick <= tick + 32'h1;
      end
   end
   // Result and filter update only at conversion end
   always_ff @(posedge clk) begin
      if (srst) begin
         result <= '0;
         flag_raw <= 1'b1;
         run <= '0;
      end else if (conv_end) begin
         result <= {temp, 4'h0};
         if (hit) begin
            flag_raw <= ~flag_raw;
            run <= '0;
         end else begin
            run <= qual ? run + 3'h1 : 3'h0;
         end
      end
   end
   // Latched event cleared by any read; set wins over clear
   always_ff @(posedge clk) begin
      if (srst) latched <= 1'b0;
      else if (hit) latched <= 1'b1;
      else if (rd_go | ctrl[tsr_pkg::SLEEP_BIT]) latched <= 1'b0;
   end
   // Read data shift: reload once this frame's pointer is in, shift on falling link clock
   wire sclk_fall = ~s_q[2] & frame_on & (bitcnt >= 5'h3);
   logic sclk_d;
   always_ff @(posedge clk) begin
      if (srst) begin
         tx <= '0;
         sclk_d <= 1'b0;
         dev_dat <= 1'b0;
         dev_dat_oe <= 1'b0;
         over_temp <= 1'b1;
         rd_frame <= 1'b0;
         tx_load <= 1'b0;
      end else begin
         sclk_d <= s_q[2];
         over_temp <= next_over_temp;
         tx_load <= ptr_go;
         // Write flag sits just above the first pointer bit at that edge
         if (ptr_go) rd_frame <= ~shreg[1];
         if (~frame_on) begin
            tx <= rd_img;
            dev_dat_oe <= 1'b0;
         end else if (tx_load) begin
            tx <= rd_img;
         end else if (sclk_fall & sclk_d & rd_frame) begin
            dev_dat <= tx[15];
            tx <= {tx[14:0], 1'b0};
            dev_dat_oe <= 1'b1;
         end
      end
   end
   assign link.dev_dat = dev_dat;
   assign link.dev_dat_oe = dev_dat_oe;
   assign link.over_temp = over_temp;
endmodule // tsr_device
`default_nettype wire

// >>> core/tsr_host.sv
// Host end: drives link clock by divider, runs write and read frames
`timescale 1ns/10ps
`default_nettype none
module tsr_host (
   input wire logic clk,
   input wire logic srst,
   tsr_link_if.host link,
   input wire logic [1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   output logic busy,
   output logic done
);
   localparam int N = tsr_pkg::FRAME_BITS;
   tsr_pkg::tsr_link_t state;
   logic [N-1:0] sh;
   logic [4:0] cnt;
   logic [3:0] div;
   logic lclk;
   logic frame;
   logic [1:0] s_dat;
   logic [15:0] rx;
   logic is_rd;
   wire half = (div == 4'(tsr_pkg::LINK_HALF - 1));
   // Transfers: 19 bits; read frames carry write flag zero
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= tsr_pkg::TSR_IDLE;
         sh <= '0;
         cnt <= '0;
         div <= '0;
         lclk <= 1'b0;
         frame <= 1'b0;
         s_dat <= '0;
         rx <= '0;
         rdata <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         is_rd <= 1'b0;
      end else begin
         s_dat <= {s_dat[0], link.dev_dat};
         done <= 1'b0;
         div <= half ? 4'h0 : div + 4'h1;
         unique case (state)
            tsr_pkg::TSR_IDLE: begin
               div <= '0;
               if (wr | rd) begin
                  // Pointer travels in every frame, so it is always set first
                  sh <= {wr, addr, wr ? wdata : 16'h0000};
                  is_rd <= rd;
                  frame <= 1'b1;
                  busy <= 1'b1;
                  cnt <= '0;
                  state <= tsr_pkg::TSR_SHIFT;
               end
            end
            tsr_pkg::TSR_SHIFT: if (half) begin
               lclk <= ~lclk;
               if (lclk) begin
                  sh <= {sh[N-2:0], 1'b0};
                  cnt <= cnt + 5'h1;
                  if (cnt == 5'(N - 1)) state <= tsr_pkg::TSR_ACK;
               end else if (cnt > 5'h3) begin
                  rx <= {rx[14:0], s_dat[1]};
               end
            end
            tsr_pkg::TSR_ACK: if (half) begin
               rx <= {rx[14:0], s_dat[1]};
               frame <= 1'b0;
               state <= tsr_pkg::TSR_DONE;
            end
            tsr_pkg::TSR_DONE: if (half) begin
               if (is_rd) rdata <= rx;
               busy <= 1'b0;
               done <= 1'b1;
               state <= tsr_pkg::TSR_IDLE;
            end
         endcase
      end
   end
   assign link.link_clk = lclk;
   assign link.frame = frame;
   assign link.host_dat = sh[N-1];
endmodule // tsr_host
`default_nettype wire

// >>> core/tsr_link_if.sv
// Serial link between host and sensor: clock, frame select, data both ways
`timescale 1ns/10ps
`default_nettype none
interface tsr_link_if;
   logic link_clk;
   logic frame;
   logic host_dat;
   logic dev_dat;
   logic dev_dat_oe;
   logic over_temp;
   modport host (output link_clk, output frame, output host_dat, input dev_dat,
      input dev_dat_oe, input over_temp);
   modport dev (input link_clk, input frame, input host_dat, output dev_dat,
      output dev_dat_oe, output over_temp);
endinterface
`default_nettype wire

// >>> core/tsr_pkg.sv
// Shared constants and types of the temperature sensor register block
package tsr_pkg;
   // Register pointer codes
   localparam logic [1:0] PTR_RESULT = 2'h0;
   localparam logic [1:0] PTR_CONTROL = 2'h1;
   localparam logic [1:0] PTR_LOWER = 2'h2;
   localparam logic [1:0] PTR_UPPER = 2'h3;
   // Control word field positions
   localparam int FLAG_BIT = 5;
   localparam int PERIOD_LO = 6;
   localparam int SLEEP_BIT = 8;
   localparam int LATCH_BIT = 9;
   localparam int SENSE_BIT = 10;
   localparam int FAULT_LO = 11;
   localparam int SHOT_BIT = 15;
   // Writable control bits; bit 4 is stored but kept as written
   localparam logic [15:0] CTRL_WMASK = 16'h9fd0;
   localparam logic [15:0] CTRL_ONES = 16'h4000;
   localparam logic [15:0] CTRL_RESET = 16'h40a0;
   localparam logic [15:0] LOWER_RESET = 16'h4b00;
   localparam logic [15:0] UPPER_RESET = 16'h5000;
   localparam logic [15:0] LIMIT_MASK = 16'hfff0;
   localparam logic [1:0] PERIOD_RESET = 2'h2;
   // Clock rate and timing
   localparam longint CLK_HZ = 10_000_000;
   localparam longint CONV_US = 34_000;
   localparam longint CONV_CYC = CONV_US * CLK_HZ / 1_000_000;
   localparam longint PER_4S_MS = 4000;
   localparam longint PER_1S_MS = 1000;
   localparam longint PER_250_MS = 250;
   localparam longint PER_125_MS = 125;
   localparam longint PER_4S_CYC = PER_4S_MS * CLK_HZ / 1000;
   localparam longint PER_1S_CYC = PER_1S_MS * CLK_HZ / 1000;
   localparam longint PER_250_CYC = PER_250_MS * CLK_HZ / 1000;
   localparam longint PER_125_CYC = PER_125_MS * CLK_HZ / 1000;
   // Link clock divider half period in system cycles
   localparam int LINK_HALF = 4;
   typedef enum logic [3:0] {
      TSR_IDLE = 4'b0001,
      TSR_SHIFT = 4'b0010,
      TSR_ACK = 4'b0100,
      TSR_DONE = 4'b1000
   } tsr_link_t;
   // Frame: write flag, pointer, 16 data bits, msb first
   localparam int FRAME_BITS = 19;
endpackage

// >>> core/tsr_sync.sv
// Two-stage synchroniser plus rising-edge pulse for link inputs
`timescale 1ns/10ps
`default_nettype none
module tsr_sync #(
   parameter int W = 3
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q,
   output logic [W-1:0] rise
);
   logic [W-1:0] meta;
   logic [W-1:0] prev;
   // First stage read only by the second
   always_ff @(posedge clk) begin
      if (srst) begin
         meta <= '0;
         q <= '0;
         prev <= '0;
      end else begin
         meta <= d;
         q <= meta;
         prev <= q;
      end
   end
   assign rise = q & ~prev;
endmodule // tsr_sync
`default_nettype wire

// >>> verification/tsr_bench.sv
// Self-checking bench joining host and sensor ends over the link
`timescale 1ns/10ps
`default_nettype none
module tsr_bench;
   typedef struct {logic chk; logic [15:0] val; logic [15:0] mask;} tsr_note_t;
   localparam int PER [4] = '{1600, 800, 400, 200};
   logic clk, srst, wr, rd, busy, done, conv_busy;
   logic [1:0] addr;
   logic [15:0] wdata, rdata, v;
   logic [11:0] sensor_code;
   logic [7:0] pointer;
   int mismatches, check_count, n, h, l;
   tsr_note_t notes[$];
   tsr_note_t note;
   tsr_link_if link();
   tsr_host tsr_host_inst (.clk(clk), .srst(srst), .link(link), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .busy(busy), .done(done));
   tsr_device #(.CONV_CYCLES(20), .P0_CYCLES(1600), .P1_CYCLES(800), .P2_CYCLES(400),
      .P3_CYCLES(200)) tsr_device_inst (.clk(clk), .srst(srst), .link(link),
      .sensor_code(sensor_code), .conv_busy(conv_busy), .pointer(pointer));
   tsr_link_assertions tsr_link_assertions_inst (.clk(clk), .srst(srst),
      .link_clk(link.link_clk), .frame(link.frame), .host_dat(link.host_dat),
      .dev_dat(link.dev_dat), .dev_dat_oe(link.dev_dat_oe), .over_temp(link.over_temp));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One frame; every frame leaves a note, only reads are compared
   task automatic xfer(input logic w, input logic [1:0] a, input logic [15:0] d,
         input logic [15:0] m);
      int k;
      k = 0;
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      notes.push_back('{!w, d, m});
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      do begin @(posedge clk); k++; end while (done !== 1'b1 && k < 400);
      check("done_busy", {14'h0000, done, busy}, 16'h0002);
   endtask
   // Waits for conversion activity to reach a level, counting cycles
   task automatic wait_busy(input logic lvl, output int c);
      c = 0;
      do begin @(posedge clk); c++; end while (conv_busy !== lvl && c < 2000);
      check("conv_busy", {15'h0000, conv_busy}, {15'h0000, lvl});
   endtask
   task automatic wait_end();
      int c;
      wait_busy(1'b1, c);
      wait_busy(1'b0, c);
   endtask
   // Monitor: read data against the oldest note whenever a frame completes
   always @(posedge clk) begin
      if (done === 1'b1 && notes.size() > 0) begin
         note = notes.pop_front();
         if (note.chk) check("rdata", rdata & note.mask, note.val & note.mask);
      end
   end
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Hang guard well beyond the expected run
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      print_verdict();
   end
   initial begin
      srst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 2'h0;
      wdata = 16'h0000;
      sensor_code = 12'h190;
      void'($urandom(55208));
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      check("conv_busy", {15'h0000, conv_busy}, 16'h0001);
      xfer(1'b0, tsr_pkg::PTR_CONTROL, 16'h40a0, 16'hffff);
      xfer(1'b0, tsr_pkg::PTR_LOWER, 16'h4b00, 16'hffff);
      xfer(1'b0, tsr_pkg::PTR_UPPER, 16'h5000, 16'hffff);
      check("pointer", {8'h00, pointer}, 16'h0003);
      $display("reset values done");
      wait_end();
      sensor_code <= 12'h1a0;
      xfer(1'b1, tsr_pkg::PTR_RESULT, 16'hffff, 16'hffff);
      xfer(1'b0, tsr_pkg::PTR_RESULT, 16'h1900, 16'hffff);
      wait_end();
      xfer(1'b0, tsr_pkg::PTR_RESULT, 16'h1a00, 16'hffff);
      $display("result updates done");
      for (int c = 0; c < 4; c++) begin
         xfer(1'b1, tsr_pkg::PTR_CONTROL, 16'(c) << 6, 16'hffff);
         wait_busy(1'b0, n);
         wait_busy(1'b1, n);
         wait_busy(1'b0, h);
         wait_busy(1'b1, l);
         check("busy_len", 16'(h), 16'd20);
         check("period", 16'(h + l), 16'(PER[c]));
      end
      $display("periods done");
      xfer(1'b1, tsr_pkg::PTR_CONTROL, 16'h7fef, 16'hffff);
      xfer(1'b0, tsr_pkg::PTR_CONTROL, 16'h5fc0, 16'hffdf);
      // Random limits; the low nibble must drop out
      for (int i = 0; i < 4; i++) begin
         v = 16'($urandom);
         xfer(1'b1, 2'h2 + 2'(i % 2), v, 16'hffff);
         xfer(1'b0, 2'h2 + 2'(i % 2), v & tsr_pkg::LIMIT_MASK, 16'hffff);
         check("pointer", {8'h00, pointer}, 16'h0002 + 16'(i % 2));
      end
      xfer(1'b1, tsr_pkg::PTR_LOWER, 16'h4b00, 16'hffff);
      xfer(1'b1, tsr_pkg::PTR_UPPER, 16'h5000, 16'hffff);
      $display("limits done");
      // Fault filter: one broken run, then exactly f+1 conversions flip the pin
      for (int f = 0; f < 4; f++) begin
         xfer(1'b1, tsr_pkg::PTR_CONTROL, 16'h00c0 | (16'(f) << 11), 16'hffff);
         sensor_code <= 12'h100;
         repeat (5) wait_end();
         sensor_code <= 12'h600;
         wait_end();
         sensor_code <= 12'h100;
         wait_end();
         sensor_code <= 12'h600;
         for (int k = 1; k <= f + 1; k++) begin
            wait_end();
            repeat (3) @(posedge clk);
            check("over_temp", {15'h0000, link.over_temp}, 16'(k <= f));
         end
         xfer(1'b0, tsr_pkg::PTR_CONTROL, 16'h40c0 | (16'(f) << 11), 16'hffff);
         sensor_code <= 12'h100;
         for (int k = 1; k <= f + 1; k++) begin
            wait_end();
            repeat (3) @(posedge clk);
            check("over_temp", {15'h0000, link.over_temp}, 16'(k > f));
         end
      end
      $display("fault filter done");
      // Latched mode, active high: an event holds the pin until any read
      xfer(1'b1, tsr_pkg::PTR_CONTROL, 16'h06c0, 16'hffff);
      xfer(1'b0, tsr_pkg::PTR_CONTROL, 16'h46c0, 16'hffff);
      repeat (2) @(posedge clk);
      check("over_temp", {15'h0000, link.over_temp}, 16'h0000);
      sensor_code <= 12'h600;
      wait_end();
      repeat (3) @(posedge clk);
      check("over_temp", {15'h0000, link.over_temp}, 16'h0001);
      xfer(1'b0, tsr_pkg::PTR_CONTROL, 16'h46e0, 16'hffff);
      repeat (2) @(posedge clk);
      check("over_temp", {15'h0000, link.over_temp}, 16'h0000);
      $display("latched mode done");
      print_verdict();
   end
endmodule // tsr_bench
`default_nettype wire

// >>> verification/tsr_link_assertions.sv
// Wire-level checks on the link joining host and sensor ends
`timescale 1ns/10ps
`default_nettype none
module tsr_link_assertions (
   input wire logic clk,
   input wire logic srst,
   input wire logic link_clk,
   input wire logic frame,
   input wire logic host_dat,
   input wire logic dev_dat,
   input wire logic dev_dat_oe,
   input wire logic over_temp
);
   localparam int FRAME_MAX = 200;
   logic [7:0] rises;
   logic [8:0] len;
   logic lc_q;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Count link clock rises and cycles within each frame; cleared between frames
   always_ff @(posedge clk) begin
      lc_q <= link_clk;
      if (srst || !frame) begin
         rises <= 8'h00;
         len <= 9'h000;
      end else begin
         len <= len + 9'h001;
         if (link_clk && !lc_q) rises <= rises + 8'h01;
      end
   end
   sequence high_phase; link_clk [*4]; endsequence
   sequence low_phase; !link_clk [*4]; endsequence
   // Device sees frame through a synchroniser, so allow it a few cycles to let go
   sequence frame_gone; !frame [*6]; endsequence
   idle_clock_a: assert property (!frame && !$past(frame) |-> !link_clk)
      else $error("link clock moves outside a frame");
   frame_start_a: assert property ($rose(frame) |-> !link_clk)
      else $error("frame opened with link clock high");
   clock_high_a: assert property ($rose(link_clk) |-> high_phase)
      else $error("link clock high phase too short");
   clock_low_a: assert property ($fell(link_clk) |-> low_phase)
      else $error("link clock low phase too short");
   bit_count_a: assert property ($fell(frame) |-> rises == 8'(tsr_pkg::FRAME_BITS))
      else $error("frame carried wrong number of bits");
   frame_len_a: assert property (frame |-> len < FRAME_MAX)
      else $error("frame lasted too long");
   data_hold_a: assert property (link_clk && $past(link_clk) |-> $stable(host_dat))
      else $error("host data moved while link clock high");
   oe_idle_a: assert property (frame_gone |-> !dev_dat_oe)
      else $error("device drives data outside a frame");
   alert_reset_a: assert property ($fell(srst) |-> over_temp)
      else $error("over-temperature pin active after reset");
   frame_seen_c: cover property ($fell(frame));
endmodule // tsr_link_assertions
`default_nettype wire
